// ===== design/setws_sync.sv
module setws_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  if (W < 1) begin : g_bad_width
    $error("setws_sync: width must be at least 1");
  end

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// ===== design/setws_top.sv
// ****************************************
// two-wire eeprom slave, write path
// ****************************************
// Behaviour
// - data falling while clock high is start; every transaction opens with it
// - data rising while clock high is stop
// - stop during a read abandons it and returns to standby
// - stop during a write ends data intake and starts programming
// - data changes only with clock low; changes with clock high are framing
// - bytes are 8 bits; receiver pulls data low in the ninth clock
// - while programming, no byte is acknowledged, not even the device address
// - 7-bit device address plus direction bit; upper four bits must be 1010
// - smallest part compares three address bits with three straps
// - two-block part compares two bits, last bit picks the block
// - four-block part compares one bit, next two pick the block
// - eight-block part compares nothing, three bits pick the block
// - open strap pins read as low
// - byte write: address, word address, data, each acked, stop programs
// - page holds 8 bytes in smallest part, 16 in larger parts
// - each further data byte is acked and goes to the next word address
// - programming touches only the locations that actually received bytes
// - smallest part: low 3 word bits advance and wrap, high 5 fixed
// - larger parts: low 4 word bits advance and wrap, rest fixed
// - every location starts out holding ff
// - write guard high blocks memory writes; low permits them
// - with the guard active, data bytes are not acknowledged
//
// The plain strobed port and the placing of the registers are this design's own decisions.
module setws_top
  import setws_pkg::*;
#(
  parameter int MEM_BYTES = 2048,
  parameter int WR_CYCLES = WR_CYCLES_DFLT
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_strap_0,
  input wire logic addr_strap_1,
  input wire logic addr_strap_2,
  input wire logic write_guard,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);

  localparam int BLK_W = $clog2(MEM_BYTES / BLOCK_BYTES);
  localparam int ADDR_W = 8 + BLK_W;
  localparam int PAGE_W = (MEM_BYTES == BLOCK_BYTES) ? PAGE_W_SMALL : PAGE_W_LARGE;
  localparam int PAGE_N = 1 << PAGE_W;
  localparam logic [2:0] BLK_MASK = 3'((1 << BLK_W) - 1);
  localparam logic [FULL_ADDR_W-1:0] PAGE_MASK = FULL_ADDR_W'(PAGE_N - 1);

  if (MEM_BYTES != 256 && MEM_BYTES != 512 && MEM_BYTES != 1024 && MEM_BYTES != 2048)
  begin : g_bad_size
    $error("setws_top: capacity must be 256, 512, 1024 or 2048 bytes");
  end

  // ****************************************
  // pin synchronisers and edge finding
  // ****************************************
  logic [5:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic guard_s;
  logic [2:0] strap_s;
  logic scl_d_r;
  logic sda_d_r;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // straps have pull-downs; an open strap arrives here as 0
  // clock and data leave reset at their idle high level, so no false edge follows
  setws_sync #(.W(6), .RST_VAL(6'h03)) u_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .d({write_guard, addr_strap_2, addr_strap_1, addr_strap_0, sda_in, scl_in}),
    .q(pins_s)
  );

  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign strap_s = pins_s[4:2];
  assign guard_s = pins_s[5];

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;
  // a data edge with clock held high is framing, never data
  assign start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_det = scl_s && scl_d_r && !sda_d_r && sda_s;

  // ****************************************
  // byte framing
  // ****************************************
  setws_state_e state_r;
  logic active;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic ack_fire;
  logic byte_done;
  logic busy;
  logic strap_ok;
  logic dev_ok;
  logic ack_ok;

  assign active = state_r == ST_DEV || state_r == ST_WORD || state_r == ST_DATA;
  assign ack_fire = active && scl_fall && bit_cnt_r == ACK_SLOT;
  assign byte_done = active && scl_fall && bit_cnt_r == BYTE_END;

  // bits are taken on the rising clock, so the fall after start counts nothing
  always_ff @(posedge clk_sys) begin
    if (srst || start_det || stop_det) begin
      bit_cnt_r <= '0;
    end else if (byte_done) begin
      bit_cnt_r <= '0;
    end else if (active && scl_rise && bit_cnt_r < BYTE_END) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      shift_r <= '0;
    end else if (active && scl_rise && bit_cnt_r < ACK_SLOT) begin
      shift_r <= {shift_r[6:0], sda_s};
    end
  end

  always_comb begin
    strap_ok = 1'b1;
    for (int i = 0; i < STRAP_N; i++) begin
      if (i >= BLK_W && shift_r[i+1] != strap_s[i]) begin
        strap_ok = 1'b0;
      end
    end
  end

  assign dev_ok = shift_r[7:4] == DEV_CODE && strap_ok && !busy;

  always_comb begin
    case (state_r)
      ST_DEV: ack_ok = dev_ok;
      ST_WORD: ack_ok = 1'b1;
      ST_DATA: ack_ok = !guard_s;
      default: ack_ok = 1'b0;
    endcase
  end

  // ****************************************
  // transaction state
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_r <= ST_IDLE;
    end else if (start_det) begin
      state_r <= ST_DEV;
    end else if (stop_det) begin
      state_r <= ST_IDLE;
    end else if (ack_fire && state_r == ST_DEV && !dev_ok) begin
      state_r <= ST_SKIP;
    end else if (byte_done) begin
      case (state_r)
        ST_DEV: state_r <= shift_r[0] ? ST_READ : ST_WORD;
        ST_WORD: state_r <= ST_DATA;
        ST_DATA: state_r <= ST_DATA;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // open drain: the pin is only ever pulled low
  assign sda_out = 1'b0;

  always_ff @(posedge clk_sys) begin
    if (srst || start_det || stop_det) begin
      sda_oe <= 1'b0;
    end else if (ack_fire && ack_ok) begin
      sda_oe <= 1'b1;
    end else if (byte_done) begin
      sda_oe <= 1'b0;
    end
  end

  // ****************************************
  // address capture and page buffer
  // ****************************************
  logic [2:0] blk_r;
  logic [7:0] word_r;
  logic [7:0] page_buf_r [PAGE_N];
  logic [PAGE_N-1:0] page_vld_r;
  logic data_take;
  logic prog_go;

  assign data_take = ack_fire && state_r == ST_DATA && !guard_s;
  assign prog_go = stop_det && state_r == ST_DATA && (|page_vld_r) && !busy;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      blk_r <= '0;
    end else if (ack_fire && state_r == ST_DEV && dev_ok) begin
      blk_r <= shift_r[3:1] & BLK_MASK;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      word_r <= '0;
    end else if (ack_fire && state_r == ST_WORD) begin
      word_r <= shift_r;
    end else if (data_take) begin
      // high word bits and block stay put, low bits wrap in the page
      word_r[PAGE_W-1:0] <= word_r[PAGE_W-1:0] + PAGE_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (data_take) begin
      page_buf_r[word_r[PAGE_W-1:0]] <= shift_r;
    end
  end

  // a new addressed write forgets the previous page; repeats overwrite a slot
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      page_vld_r <= '0;
    end else if (ack_fire && state_r == ST_DEV && dev_ok) begin
      page_vld_r <= '0;
    end else if (data_take) begin
      page_vld_r[word_r[PAGE_W-1:0]] <= 1'b1;
    end
  end

  // ****************************************
  // programming cycle
  // ****************************************
  logic copying_r;
  logic [PAGE_W-1:0] copy_idx_r;
  logic [FULL_ADDR_W-1:0] copy_addr;
  logic [7:0] mem_r [MEM_BYTES];

  setws_wtimer #(.CYCLES(WR_CYCLES)) u_wtimer (
    .clk_sys(clk_sys),
    .srst(srst),
    .start(prog_go),
    .busy(busy)
  );

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      copying_r <= 1'b0;
      copy_idx_r <= '0;
    end else if (prog_go) begin
      copying_r <= 1'b1;
      copy_idx_r <= '0;
    end else if (copying_r) begin
      copy_idx_r <= copy_idx_r + PAGE_W'(1);
      copying_r <= copy_idx_r != PAGE_W'(PAGE_N - 1);
    end
  end

  assign copy_addr = ({blk_r, word_r} & ~PAGE_MASK) | FULL_ADDR_W'(copy_idx_r);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int i = 0; i < MEM_BYTES; i++) begin
        mem_r[i] <= ERASED_BYTE;
      end
    end else if (copying_r && page_vld_r[copy_idx_r]) begin
      mem_r[copy_addr[ADDR_W-1:0]] <= page_buf_r[copy_idx_r];
    end
  end

  // ****************************************
  // register port
  // ****************************************
  logic [ADDR_W-1:0] maddr_r;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      maddr_r <= '0;
    end else if (reg_wr && reg_addr == OFS_MADDR) begin
      maddr_r <= reg_wdata[ADDR_W-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_STATUS: begin
          reg_rdata <= '0;
          reg_rdata[STATUS_BUSY_BIT] <= busy;
          reg_rdata[STATUS_GUARD_BIT] <= guard_s;
        end
        OFS_MADDR: reg_rdata <= 32'(maddr_r);
        OFS_MDATA: reg_rdata <= {24'h000000, mem_r[maddr_r]};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence s_dev_ack;
    ack_fire && state_r == ST_DEV && dev_ok;
  endsequence

  sequence s_data_take;
    ack_fire && state_r == ST_DATA && !guard_s;
  endsequence

  a_start_opens: assert property (start_det |=> state_r == ST_DEV && bit_cnt_r == 4'h0)
    else $error("start did not open address phase");
  a_stop_ends: assert property (stop_det |=> state_r == ST_IDLE && !sda_oe)
    else $error("stop did not return to standby");
  a_read_abandon: assert property (stop_det && state_r == ST_READ |=> !busy)
    else $error("stop in read started programming");
  a_stop_programs: assert property (prog_go |=> busy && copying_r)
    else $error("stop after data did not start programming");
  a_busy_silent: assert property (busy && !$past(sda_oe) |-> !sda_oe)
    else $error("acknowledge driven while programming");
  a_ack_slot: assert property ($rose(sda_oe) |-> bit_cnt_r == ACK_SLOT)
    else $error("acknowledge outside ninth clock");
  a_dev_match: assert property (s_dev_ack |=> sda_oe ##0 $past(shift_r[7:4]) == DEV_CODE)
    else $error("address acknowledged without device code");
  a_guard_nack: assert property (ack_fire && state_r == ST_DATA && guard_s |=> !sda_oe)
    else $error("data acknowledged with write guard high");
  a_page_wrap: assert property (s_data_take |=>
      word_r[7:PAGE_W] == $past(word_r[7:PAGE_W]) &&
      word_r[PAGE_W-1:0] == $past(word_r[PAGE_W-1:0]) + PAGE_W'(1))
    else $error("page address did not wrap in place");
  a_mismatch_quiet: assert property (state_r == ST_SKIP |-> !sda_oe)
    else $error("data line driven after address mismatch");
  a_erased_init: assert property ($fell(srst) |-> mem_r[0] == ERASED_BYTE)
    else $error("memory not erased after reset");

endmodule

// ===== design/setws_wtimer.sv
module setws_wtimer #(
  parameter int CYCLES = 16
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic start,
  output logic busy
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_r;

  if (CYCLES < 16) begin : g_bad_cycles
    $error("setws_wtimer: write time must cover the page copy");
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_r <= '0;
    end else if (start && cnt_r == '0) begin
      cnt_r <= CW'(CYCLES);
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - CW'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      busy <= 1'b0;
    end else begin
      busy <= (start && cnt_r == '0) || cnt_r > CW'(1);
    end
  end

endmodule

// ===== pkg/setws_pkg.sv
package setws_pkg;

  // ****************************************
  // bus framing and addressing
  // ****************************************
  localparam logic [3:0] DEV_CODE = 4'ha;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] BYTE_END = 4'h9;
  localparam int BLOCK_BYTES = 256;
  localparam int STRAP_N = 3;
  localparam int PAGE_W_SMALL = 3;
  localparam int PAGE_W_LARGE = 4;
  localparam int FULL_ADDR_W = 11;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int WR_TIME_NS = 5000000;
  localparam int WR_CYCLES_DFLT = WR_TIME_NS / CLK_PERIOD_NS;

  // ****************************************
  // register port
  // ****************************************
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_MADDR = 8'h04;
  localparam logic [7:0] OFS_MDATA = 8'h08;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_GUARD_BIT = 1;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_DEV  = 6'b000010,
    ST_WORD = 6'b000100,
    ST_DATA = 6'b001000,
    ST_READ = 6'b010000,
    ST_SKIP = 6'b100000
  } setws_state_e;

endpackage

// ===== tb/setws_master.sv
// ****************************************
// two-wire bus master model
// ****************************************
module setws_master (
  output logic scl,
  output logic sda,
  input wire logic sda_line
);
  timeunit 1ns;
  timeprecision 1ps;

  // clock stands high between frames, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // offset keeps pin changes away from clk_sys edges
  task automatic start_c();
    #7;
    sda = 1'b1;
    #40;
    scl = 1'b1;
    #40;
    sda = 1'b0;
    #80;
    scl = 1'b0;
  endtask

  task automatic stop_c();
    #20;
    sda = 1'b0;
    #60;
    scl = 1'b1;
    #80;
    sda = 1'b1;
    #80;
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #20;
      sda = b[i];
      #60;
      scl = 1'b1;
      #80;
      scl = 1'b0;
    end
    #20;
    sda = 1'b1;
    #60;
    scl = 1'b1;
    #60;
    ack = ~sda_line;
    #20;
    scl = 1'b0;
  endtask
endmodule

// ===== tb/testbench.sv
module testbench
  import setws_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // signals and instances
  // ****************************************
  // long enough that a busy device sees a whole address byte
  localparam int WRC = 400;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [2:0] straps = 3'b101;
  logic strap_hi = 1'b0;
  logic sel_b = 1'b0;
  logic [31:0] rdata_b;
  logic sda_out_b;
  logic sda_oe_b;
  logic [7:0] eb [18];
  logic write_guard = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic sda_out;
  logic sda_oe;
  logic m_scl;
  logic m_sda;
  wire logic sda_line;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [7:0] e [256];
  logic [7:0] pg [$];
  logic [7:0] none [$];
  logic [31:0] d;

  always #10 clk_sys = ~clk_sys;
  assign sda_line = m_sda & ~(sda_oe & ~sda_out) & ~(sda_oe_b & ~sda_out_b);

  setws_top #(.MEM_BYTES(256), .WR_CYCLES(WRC)) dut (
    .clk_sys(clk_sys),
    .srst(srst),
    .scl_in(m_scl),
    .sda_in(sda_line),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .addr_strap_0(straps[0]),
    .addr_strap_1(straps[1]),
    .addr_strap_2(straps[2]),
    .write_guard(write_guard),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
  );

  // four-block part on the same wire; only address bit 3 meets its strap
  setws_top #(.MEM_BYTES(1024), .WR_CYCLES(WRC)) dut_b (
    .clk_sys(clk_sys),
    .srst(srst),
    .scl_in(m_scl),
    .sda_in(sda_line),
    .sda_out(sda_out_b),
    .sda_oe(sda_oe_b),
    .addr_strap_0(straps[0]),
    .addr_strap_1(straps[1]),
    .addr_strap_2(strap_hi),
    .write_guard(write_guard),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(rdata_b)
  );

  setws_master m (
    .scl(m_scl),
    .sda(m_sda),
    .sda_line(sda_line)
  );

  // ****************************************
  // tasks
  // ****************************************
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    v = sel_b ? rdata_b : reg_rdata;
  endtask

  task automatic mem_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] v;
    reg_write(OFS_MADDR, {24'h0, a});
    reg_read(OFS_MDATA, v);
    chk(v, {24'h0, exp}, "memory byte");
  endtask

  task automatic wait_idle();
    logic [31:0] v;
    for (int i = 0; i < 300; i++) begin
      reg_read(OFS_STATUS, v);
      if (v[0] === 1'b0) break;
    end
    chk({31'h0, v[0]}, 32'h0, "busy cleared");
  endtask

  // first n_ack bytes (device address included) must be acknowledged
  task automatic xfer(input logic [7:0] dev, input logic [7:0] bs [$], input int n_ack);
    logic ack;
    m.start_c();
    m.put_byte(dev, ack);
    chk({31'h0, ack}, (n_ack > 0) ? 32'h1 : 32'h0, "address ack");
    foreach (bs[i]) begin
      m.put_byte(bs[i], ack);
      chk({31'h0, ack}, (i + 1 < n_ack) ? 32'h1 : 32'h0, "byte ack");
    end
    m.stop_c();
  endtask

  // ****************************************
  // timeout and main sequence
  // ****************************************
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      $display("mismatch at %0t: run timed out", $time);
      give_verdict();
    end
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    foreach (e[i]) e[i] = ERASED_BYTE;
    mem_chk(8'h00, ERASED_BYTE);
    mem_chk(8'hff, ERASED_BYTE);
    reg_read(OFS_MADDR, d);
    chk(d, 32'h0ff, "memory index readback");
    reg_read(OFS_STATUS, d);
    chk(d, 32'h0, "status after reset");
    reg_read(8'h0c, d);
    chk(d, 32'h0, "unmapped read");
    xfer(8'haa, '{8'h10, 8'h5a}, 3);
    reg_read(OFS_STATUS, d);
    chk(d, 32'h1, "busy after stop");
    xfer(8'haa, none, 0);
    wait_idle();
    e[8'h10] = 8'h5a;
    mem_chk(8'h10, e[8'h10]);
    mem_chk(8'h11, e[8'h11]);
    xfer(8'ha8, '{8'h10, 8'h00}, 0);
    xfer(8'hba, '{8'h10, 8'h00}, 0);
    reg_read(OFS_STATUS, d);
    chk(d, 32'h0, "no programming after mismatch");
    xfer(8'hab, none, 1);
    pg.push_back(8'h1e);
    for (int k = 0; k < 10; k++) begin
      pg.push_back(8'(8'hd0 + k));
      e[8'h18 | ((8'h1e + k) & 8'h07)] = 8'(8'hd0 + k);
    end
    xfer(8'haa, pg, 12);
    wait_idle();
    for (int a = 8'h17; a <= 8'h20; a++) begin
      mem_chk(8'(a), e[a]);
    end
    sel_b = 1'b1;
    foreach (eb[i]) eb[i] = ERASED_BYTE;
    pg.delete();
    pg.push_back(8'h35);
    for (int k = 0; k < 18; k++) begin
      pg.push_back(8'(8'h60 + k));
      eb[1 + ((5 + k) & 15)] = 8'(8'h60 + k);
    end
    xfer(8'ha4, pg, 20);
    wait_idle();
    for (int s = 0; s < 18; s++) begin
      reg_write(OFS_MADDR, 32'h22f + 32'(s));
      reg_read(OFS_MDATA, d);
      chk(d, {24'h0, eb[s]}, "four-block page byte");
    end
    mem_chk(8'h30, ERASED_BYTE);
    sel_b = 1'b0;
    @(posedge clk_sys);
    straps <= 3'b000;
    strap_hi <= 1'b1;
    write_guard <= 1'b1;
    repeat (4) @(posedge clk_sys);
    xfer(8'ha0, '{8'h18, 8'h33}, 2);
    reg_read(OFS_STATUS, d);
    chk(d, 32'h2, "guard set, no busy");
    @(posedge clk_sys);
    write_guard <= 1'b0;
    mem_chk(8'h18, e[8'h18]);
    give_verdict();
  end
endmodule
